// file: hdl/core_regs.v
// Purpose: programmer-visible registers of an 8-bit cpu core
// Assumes: sequencer issues one operation per cycle on i_op
// Notes:   memory data for each op is presented with the op itself
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_defines.vh"

module core_regs #(
   parameter DW = 8,
   parameter AW = 16
) (
   // clock and reset
   input  wire            i_clk,
   input  wire            i_sys_rst,
   // sequencer request
   input  wire [3:0]      i_op,
   input  wire [DW-1:0]   i_data,
   input  wire [DW-1:0]   i_data_x,
   input  wire [DW-1:0]   i_operand,
   input  wire [AW-1:0]   i_vector,
   // system controls
   input  wire            i_stack_page,
   input  wire            i_ring_osc,
   input  wire            i_wake,
   // memory side
   output wire [AW-1:0]   o_mem_addr,
   output wire [DW-1:0]   o_mem_wdata,
   output wire            o_mem_we,
   output wire            o_mem_re,
   // register view
   output wire [DW-1:0]   o_acc,
   output wire [DW-1:0]   o_x,
   output wire [DW-1:0]   o_y,
   output wire [DW-1:0]   o_sp,
   output wire [DW-1:0]   o_ps,
   output wire [AW-1:0]   o_pc,
   // status
   output wire            o_busy,
   output wire            o_halt,
   output wire            o_osc_stop,
   output wire            o_fault
);

////////////////////////////////////////////////////////////////////////////

reg  [DW-1:0]   acc_r;
reg  [DW-1:0]   x_r;
reg  [DW-1:0]   y_r;
reg  [DW-1:0]   sp_r;
reg  [DW-1:0]   ps_r;
reg  [AW-1:0]   pc_r;
reg  [AW-1:0]   addr_r;
reg  [DW-1:0]   wdata_r;
reg             we_r;
reg             re_r;
reg  [1:0]      state_r;
reg             int_r;
reg             halt_r;
reg             stop_r;
reg             fault_r;
reg             busy_r;

reg  [DW:0]     sum_nxt;
reg  [2*DW-1:0] prod_nxt;
reg  [2*DW-1:0] quot_nxt;
reg  [2*DW-1:0] rem_nxt;
wire            active;

// push sequencer states
localparam [1:0] ST_IDLE   = 2'h0;
localparam [1:0] ST_PUSH_H = 2'h1;
localparam [1:0] ST_PUSH_L = 2'h2;
localparam [1:0] ST_PUSH_P = 2'h3;

// stack page select on top, pointer below
function [AW-1:0] stack_addr;
   input          page;
   input [DW-1:0] ptr;
   begin
      stack_addr = {{(AW-DW-1){1'b0}}, page, ptr};
   end
endfunction

// operand plus index, carried into the high byte
function [AW-1:0] index_addr;
   input [DW-1:0] opnd;
   input [DW-1:0] idx;
   begin
      index_addr = {{(AW-DW){1'b0}}, opnd}
                 + {{(AW-DW){1'b0}}, idx};
   end
endfunction

////////////////////////////////////////////////////////////////////////////

// nothing is taken while pushing, halted or stopped
assign active = (state_r == ST_IDLE) && !halt_r && !stop_r;

always @* begin
   sum_nxt  = {1'b0, (ps_r[`PS_T] ? i_data_x : acc_r)}
            + {1'b0, i_data}
            + {{DW{1'b0}}, ps_r[`PS_C]};
   prod_nxt = acc_r * i_data;
   quot_nxt = {(2*DW){1'b0}};
   rem_nxt  = {(2*DW){1'b0}};
   // divider by zero left to the fault branch below
   if (i_operand != `BYTE_ZERO) begin
      quot_nxt = {i_data, acc_r} / {{DW{1'b0}}, i_operand};
      rem_nxt  = {i_data, acc_r} % {{DW{1'b0}}, i_operand};
   end
end

////////////////////////////////////////////////////////////////////////////

always @(posedge i_clk) begin
   if (i_sys_rst) begin
      acc_r   <= `BYTE_ZERO;
      x_r     <= `BYTE_ZERO;
      y_r     <= `BYTE_ZERO;
      sp_r    <= `SP_RST;
      ps_r    <= `PS_RST;
      pc_r    <= `PC_RST;
      addr_r  <= `PC_RST;
      wdata_r <= `BYTE_ZERO;
      we_r    <= 1'b0;
      re_r    <= 1'b0;
      state_r <= ST_IDLE;
      busy_r  <= 1'b0;
      int_r   <= 1'b0;
      halt_r  <= 1'b0;
      stop_r  <= 1'b0;
      fault_r <= 1'b0;
   end else begin
      we_r    <= 1'b0;
      re_r    <= 1'b0;
      fault_r <= 1'b0;
      // wake releases both wait and oscillator stop
      if ((halt_r || stop_r) && i_wake) begin
         halt_r <= 1'b0;
         stop_r <= 1'b0;
      end
      case (state_r)
         ST_PUSH_H: begin
            addr_r  <= stack_addr(i_stack_page, sp_r);
            wdata_r <= pc_r[AW-1:DW];
            we_r    <= 1'b1;
            sp_r    <= sp_r - `SP_STEP;
            state_r <= ST_PUSH_L;
         end
         ST_PUSH_L: begin
            addr_r  <= stack_addr(i_stack_page, sp_r);
            wdata_r <= pc_r[DW-1:0];
            we_r    <= 1'b1;
            sp_r    <= sp_r - `SP_STEP;
            if (int_r) begin
               state_r <= ST_PUSH_P;
            end else begin
               pc_r    <= i_vector;
               state_r <= ST_IDLE;
               busy_r  <= 1'b0;
            end
         end
         ST_PUSH_P: begin
            addr_r  <= stack_addr(i_stack_page, sp_r);
            wdata_r <= ps_r;
            we_r    <= 1'b1;
            sp_r    <= sp_r - `SP_STEP;
            ps_r[`PS_I] <= 1'b1;
            pc_r    <= i_vector;
            int_r   <= 1'b0;
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
         end
         default: begin
            if (active) begin
               case (i_op)
                  `OP_LDA: begin
                     acc_r <= i_data;
                  end
                  `OP_LDX: begin
                     x_r <= i_data;
                  end
                  `OP_LDY: begin
                     y_r <= i_data;
                  end
                  `OP_LDS: begin
                     sp_r <= i_data;
                  end
                  `OP_ADC: begin
                     ps_r[`PS_C] <= sum_nxt[DW];
                     ps_r[`PS_Z] <= (sum_nxt[DW-1:0] == `BYTE_ZERO);
                     if (ps_r[`PS_T]) begin
                        // memory to memory, result back at X
                        addr_r  <= {{(AW-DW){1'b0}}, x_r};
                        wdata_r <= sum_nxt[DW-1:0];
                        we_r    <= 1'b1;
                     end else begin
                        acc_r <= sum_nxt[DW-1:0];
                     end
                  end
                  `OP_MOV: begin
                     ps_r[`PS_Z] <= (i_data == `BYTE_ZERO);
                     if (ps_r[`PS_T]) begin
                        addr_r  <= {{(AW-DW){1'b0}}, x_r};
                        wdata_r <= i_data;
                        we_r    <= 1'b1;
                     end else begin
                        acc_r <= i_data;
                     end
                  end
                  `OP_EA_X: begin
                     addr_r <= index_addr(i_operand, x_r);
                     re_r   <= 1'b1;
                  end
                  `OP_EA_Y: begin
                     addr_r <= index_addr(i_operand, y_r);
                     re_r   <= 1'b1;
                  end
                  `OP_PUSHA: begin
                     addr_r  <= stack_addr(i_stack_page, sp_r);
                     wdata_r <= acc_r;
                     we_r    <= 1'b1;
                     sp_r    <= sp_r - `SP_STEP;
                  end
                  `OP_PULL: begin
                     // pre-increment; the 8-bit pointer wraps in page
                     addr_r <= stack_addr(i_stack_page,
                                          sp_r + `SP_STEP);
                     re_r   <= 1'b1;
                     sp_r   <= sp_r + `SP_STEP;
                  end
                  `OP_CALL: begin
                     int_r   <= 1'b0;
                     busy_r  <= 1'b1;
                     state_r <= ST_PUSH_H;
                  end
                  `OP_INT: begin
                     int_r   <= 1'b1;
                     busy_r  <= 1'b1;
                     state_r <= ST_PUSH_H;
                  end
                  `OP_MUL: begin
                     // low byte stays, high byte goes to the stack
                     acc_r   <= prod_nxt[DW-1:0];
                     addr_r  <= stack_addr(i_stack_page, sp_r);
                     wdata_r <= prod_nxt[2*DW-1:DW];
                     we_r    <= 1'b1;
                     sp_r    <= sp_r - `SP_STEP;
                  end
                  `OP_DIV: begin
                     if (i_operand == `BYTE_ZERO) begin
                        fault_r <= 1'b1;
                     end else begin
                        // quotient truncated to one byte
                        acc_r   <= quot_nxt[DW-1:0];
                        addr_r  <= stack_addr(i_stack_page, sp_r);
                        wdata_r <= rem_nxt[DW-1:0];
                        we_r    <= 1'b1;
                        sp_r    <= sp_r - `SP_STEP;
                     end
                  end
                  `OP_EXT: begin
                     case (i_operand[2:0])
                        `EXT_WAIT: begin
                           halt_r <= 1'b1;
                        end
                        `EXT_STOP: begin
                           // ring oscillator cannot be restarted safely
                           if (i_ring_osc) begin
                              fault_r <= 1'b1;
                           end else begin
                              stop_r <= 1'b1;
                           end
                        end
                        `EXT_FAST, `EXT_SLOW: begin
                           fault_r <= 1'b1;
                        end
                        `EXT_SETF: begin
                           ps_r <= ps_r | i_data;
                        end
                        `EXT_CLRF: begin
                           ps_r <= ps_r & ~i_data;
                        end
                        `EXT_PCINC: begin
                           pc_r <= pc_r + `PC_STEP;
                        end
                        default: begin
                           pc_r <= i_vector;
                        end
                     endcase
                  end
                  default: begin
                  end
               endcase
            end
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////

assign o_mem_addr  = addr_r;
assign o_mem_wdata = wdata_r;
assign o_mem_we    = we_r;
assign o_mem_re    = re_r;
assign o_acc       = acc_r;
assign o_x         = x_r;
assign o_y         = y_r;
assign o_sp        = sp_r;
assign o_ps        = ps_r;
assign o_pc        = pc_r;
assign o_busy      = busy_r;
assign o_halt      = halt_r;
assign o_osc_stop  = stop_r;
assign o_fault     = fault_r;

endmodule
`default_nettype wire

// file: hdl/core_regs_defines.vh
// Purpose: constants for the cpu core register set
// Assumes: included by core_regs.v, the checker and the bench
// Notes:   operation codes are issued by the instruction sequencer
`ifndef CORE_REGS_DEFINES_VH
`define CORE_REGS_DEFINES_VH

// sequencer operation codes
`define OP_NOP       4'h0
`define OP_LDA       4'h1
`define OP_LDX       4'h2
`define OP_LDY       4'h3
`define OP_LDS       4'h4
`define OP_ADC       4'h5
`define OP_MOV       4'h6
`define OP_EA_X      4'h7
`define OP_EA_Y      4'h8
`define OP_PUSHA     4'h9
`define OP_PULL      4'hA
`define OP_CALL      4'hB
`define OP_INT       4'hC
`define OP_MUL       4'hD
`define OP_DIV       4'hE
`define OP_EXT       4'hF

// sub codes of OP_EXT, taken from i_operand[2:0]
`define EXT_WAIT     3'h0
`define EXT_STOP     3'h1
`define EXT_FAST     3'h2
`define EXT_SLOW     3'h3
`define EXT_SETF     3'h4
`define EXT_CLRF     3'h5
`define EXT_PCINC    3'h6
`define EXT_PCLOAD   3'h7

// status flag positions
`define PS_C         0
`define PS_Z         1
`define PS_I         2
`define PS_T         5

// reset values and step sizes
`define PS_RST       8'h04
`define SP_RST       8'hFF
`define BYTE_ZERO    8'h00
`define PC_RST       16'h0000
`define PC_STEP      16'h0001
`define SP_STEP      8'h01

`endif

// file: verif/core_regs_checker.sv
// Purpose: port assertions for core_regs
// Assumes: one clock, sync active-high reset
// Notes:   attached by bind below the module
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_defines.vh"
module core_regs_checker (
   input wire logic        i_clk,
   input wire logic        i_sys_rst,
   input wire logic [3:0]  i_op,
   input wire logic [7:0]  i_operand,
   input wire logic [15:0] i_vector,
   input wire logic        i_stack_page,
   input wire logic        i_ring_osc,
   input wire logic        i_wake,
   input wire logic [15:0] o_mem_addr,
   input wire logic        o_mem_we,
   input wire logic        o_mem_re,
   input wire logic [7:0]  o_acc,
   input wire logic [7:0]  o_x,
   input wire logic [7:0]  o_sp,
   input wire logic [7:0]  o_ps,
   input wire logic [15:0] o_pc,
   input wire logic        o_busy,
   input wire logic        o_halt,
   input wire logic        o_osc_stop,
   input wire logic        o_fault
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // ops are only taken while nothing else runs
   wire idle = !o_busy && !o_halt && !o_osc_stop;
   wire ext = idle && i_op == `OP_EXT;
   ////////////////////////////////////////
   rst_vals_a: assert property (
      $fell(i_sys_rst) |-> o_ps[`PS_I] && o_sp == `SP_RST && o_pc == `PC_RST)
      else $error("reset values wrong");
   push_addr_a: assert property (
      idle && i_op == `OP_PUSHA |=> o_mem_we && o_sp == $past(o_sp) - 8'h01
      && o_mem_addr == {7'h00, $past(i_stack_page), $past(o_sp)})
      else $error("push address wrong");
   pull_addr_a: assert property (
      idle && i_op == `OP_PULL |=> o_mem_re && o_sp == $past(o_sp) + 8'h01
      && o_mem_addr == {7'h00, $past(i_stack_page), o_sp})
      else $error("pull address wrong");
   index_x_a: assert property (
      idle && i_op == `OP_EA_X |=> o_mem_re
      && o_mem_addr == {8'h00, $past(i_operand)} + {8'h00, $past(o_x)})
      else $error("indexed address wrong");
   t_mode_a: assert property (
      idle && i_op == `OP_ADC && o_ps[`PS_T] |=> o_mem_we
      && o_mem_addr == {8'h00, $past(o_x)} && $stable(o_acc))
      else $error("memory mode target wrong");
   clk_set_a: assert property (
      ext && i_operand[2:1] == 2'h1 |=> o_fault && $stable(o_ps))
      else $error("clock set op not refused");
   stop_ring_a: assert property (
      ext && i_operand[2:0] == `EXT_STOP && i_ring_osc |=> o_fault
      && !o_osc_stop) else $error("stop taken under ring oscillator");
   wait_halt_a: assert property (
      ext && i_operand[2:0] == `EXT_WAIT |=> o_halt && !o_mem_we)
      else $error("wait did not halt");
   call_seq_a: assert property (
      idle && i_op == `OP_CALL |=> o_busy ##1 o_mem_we ##1 o_mem_we
      ##1 !o_busy && o_pc == $past(i_vector, 2))
      else $error("call push sequence wrong");
   call_c: cover property (idle && i_op == `OP_CALL);
   int_c: cover property (idle && i_op == `OP_INT);
   wake_c: cover property (o_osc_stop && i_wake);
endmodule
bind core_regs core_regs_checker chk_i (.*);
`default_nettype wire

// file: verif/cpu_core_register_set_tb_top.sv
// Purpose: self-checking bench for core_regs
// Assumes: memory data arrives with each op
// Notes:   one idle cycle between ops keeps drives race-free
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_defines.vh"
module cpu_core_register_set_tb_top;
   logic        i_clk = 0;
   logic        i_sys_rst = 1;
   logic [3:0]  i_op = 0;
   logic [7:0]  i_data = 0;
   logic [7:0]  i_data_x = 0;
   logic [7:0]  i_operand = 0;
   logic [15:0] i_vector = 0;
   logic        i_stack_page = 0;
   logic        i_ring_osc = 0;
   logic        i_wake = 0;
   wire  [15:0] o_mem_addr, o_pc;
   wire  [7:0]  o_mem_wdata, o_acc, o_x, o_y, o_sp, o_ps;
   wire         o_mem_we, o_mem_re, o_busy, o_halt, o_osc_stop, o_fault;
   wire  [31:0] w;
   int          errors = 0, total_checks = 0, m [4], m_pc, k, n;
   integer      seed = 32'h914fd3a0;
   logic [31:0] v;
   core_regs uut (.i_clk, .i_sys_rst, .i_op, .i_data, .i_data_x, .i_operand,
      .i_vector, .i_stack_page, .i_ring_osc, .i_wake, .o_mem_addr,
      .o_mem_wdata, .o_mem_we, .o_mem_re, .o_acc, .o_x, .o_y, .o_sp, .o_ps,
      .o_pc, .o_busy, .o_halt, .o_osc_stop, .o_fault);
   mem_model mem_i (.i_clk, .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
      .i_we(o_mem_we), .i_re(o_mem_re), .o_writes(w));
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] s, e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic op(input logic [3:0] o, input logic [7:0] d, p);
      @(posedge i_clk);
      #1;
      i_op = o;
      i_data = d;
      i_operand = p;
      @(posedge i_clk);
      #1;
      i_op = `OP_NOP;
   endtask
   task automatic regs();
      chk("acc", o_acc, m[0]);
      chk("x", o_x, m[1]);
      chk("y", o_y, m[2]);
      chk("sp", o_sp, m[3]);
   endtask
   task automatic idle_wait();
      for (n = 0; n < 20 && o_busy !== 1'b0; n++) begin
         @(posedge i_clk);
         #1;
      end
      chk("busy", o_busy, 0);
      // last push lands in memory one edge later
      @(posedge i_clk);
      #1;
   endtask
   task automatic wake();
      i_wake = 1;
      @(posedge i_clk);
      #1;
      i_wake = 0;
      chk("wake", {o_halt, o_osc_stop}, 0);
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   initial begin
      #20000;
      errors++;
      finish_test();
   end
   initial begin
      m[3] = 255;
      repeat (4) @(posedge i_clk);
      #1;
      i_sys_rst = 0;
      regs();
      chk("ps", o_ps, 8'h04);
      chk("pc", o_pc, 0);
      for (k = 0; k < 4; k++) begin
         v = $random(seed);
         m[k] = v[7:0];
         op(4'(`OP_LDA + k), v[7:0], 8'h00);
      end
      regs();
      m[1] = 255;
      op(`OP_LDX, 8'hFF, 8'h00);
      op(`OP_EA_X, 8'h00, 8'hF0);
      chk("ea_x", {o_mem_re, o_mem_addr[14:0]}, 16'h81EF);
      v = $random(seed);
      op(`OP_EA_Y, 8'h00, v[7:0]);
      chk("ea_y", o_mem_addr, v[7:0] + m[2]);
      $display("index test done");
      // page one with the pointer at zero makes the push wrap
      i_stack_page = 1;
      op(`OP_LDS, 8'h00, 8'h00);
      op(`OP_PUSHA, 8'h00, 8'h00);
      chk("push", {o_mem_we, o_mem_addr[14:0]}, 16'h8100);
      chk("push_sp", {o_mem_wdata, o_sp}, {8'(m[0]), 8'hFF});
      op(`OP_PULL, 8'(m[0]), 8'h00);
      chk("pull", {o_mem_re, o_mem_addr[14:0]}, 16'h8100);
      chk("pull_sp", o_sp, 8'h00);
      chk("mem", mem_i.mem[16'h0100], m[0]);
      op(`OP_EXT, 8'h01, 8'(`EXT_CLRF));
      op(`OP_LDA, 8'hFF, 8'h00);
      op(`OP_ADC, 8'h01, 8'h00);
      chk("adc", {o_ps[1:0], o_acc}, 10'h300);
      op(`OP_ADC, 8'h05, 8'h00);
      chk("adc_c", {o_ps, o_acc}, 16'h0406);
      op(`OP_EXT, 8'h20, 8'(`EXT_SETF));
      i_data_x = 8'h10;
      op(`OP_ADC, 8'h22, 8'h00);
      chk("t_addr", o_mem_addr, 16'h00FF);
      chk("t_data", {o_mem_we, o_mem_wdata}, 9'h132);
      op(`OP_MOV, 8'h3C, 8'h00);
      chk("mov_a", o_mem_addr, 16'h00FF);
      chk("mov_t", {o_mem_we, o_mem_wdata}, 9'h13C);
      op(`OP_EXT, 8'h24, 8'(`EXT_CLRF));
      m[0] = 6;
      m[3] = 0;
      regs();
      op(`OP_MOV, 8'hC7, 8'h00);
      m[0] = 8'hC7;
      chk("mov", {o_ps, o_acc}, 16'h00C7);
      $display("stack and adc tests done");
      i_vector = 16'hA55A;
      op(`OP_EXT, 8'h00, 8'(`EXT_PCLOAD));
      op(`OP_EXT, 8'h00, 8'(`EXT_PCINC));
      chk("pc", o_pc, 16'hA55B);
      v = $random(seed);
      i_vector = v[15:0];
      k = w;
      op(`OP_CALL, 8'h00, 8'h00);
      chk("busy", o_busy, 1);
      idle_wait();
      chk("pch", mem_i.mem[16'h0100], 8'hA5);
      chk("pcl", mem_i.mem[16'h01FF], 8'h5B);
      chk("pc_v", o_pc, v[15:0]);
      m_pc = v[15:0];
      v = $random(seed);
      i_vector = v[15:0];
      op(`OP_INT, 8'h00, 8'h00);
      idle_wait();
      chk("int_h", mem_i.mem[16'h01FE], m_pc[15:8]);
      chk("int_l", mem_i.mem[16'h01FD], m_pc[7:0]);
      chk("int_ps", mem_i.mem[16'h01FC], 8'h00);
      chk("int_pc", {o_ps, o_pc[7:0]}, {8'h04, v[7:0]});
      chk("writes", w - k, 5);
      m[3] = 251;
      for (k = `EXT_FAST; k <= `EXT_SLOW; k++) begin
         op(`OP_EXT, 8'h00, 8'(k));
         chk("fault", o_fault, 1);
      end
      regs();
      $display("call and refusal tests done");
      v = $random(seed);
      k = v[7:0] * v[15:8];
      op(`OP_LDA, v[7:0], 8'h00);
      op(`OP_MUL, v[15:8], 8'h00);
      chk("prod", o_acc, k[7:0]);
      n = 18 * 256 + k[7:0];
      op(`OP_DIV, 8'h12, 8'hC3);
      chk("quot", o_acc, n / 195);
      chk("prod_hi", mem_i.mem[16'h01FB], k[15:8]);
      m[0] = n / 195;
      m[3] = 249;
      op(`OP_DIV, 8'h01, 8'h00);
      chk("div0", {o_fault, o_acc}, 256 + m[0]);
      chk("rem", mem_i.mem[16'h01FA], n % 195);
      op(`OP_EXT, 8'h00, 8'(`EXT_WAIT));
      chk("halt", o_halt, 1);
      op(`OP_LDA, 8'h5A, 8'h00);
      regs();
      wake();
      i_ring_osc = 1;
      op(`OP_EXT, 8'h00, 8'(`EXT_STOP));
      chk("ring", {o_fault, o_osc_stop}, 2'b10);
      i_ring_osc = 0;
      op(`OP_EXT, 8'h00, 8'(`EXT_STOP));
      chk("stop", o_osc_stop, 1);
      wake();
      $display("arith and halt tests done");
      finish_test();
   end
endmodule
`default_nettype wire

// file: verif/mem_model.sv
// Purpose: memory bus stand-in beside core_regs
// Assumes: write strobe is a one-cycle pulse
// Notes:   read data rides with the op, so reads get no answer
`timescale 1ns/10ps
`default_nettype none
module mem_model (
   // bus from the core
   input wire logic        i_clk,
   input wire logic [15:0] i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_we,
   input wire logic        i_re,
   // write count for the bench
   output var logic [31:0] o_writes
);
   logic [7:0]  mem [0:65535];
   logic [31:0] cnt = 0;
   assign o_writes = cnt;
   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire
